// *** src/ui_ctrl.sv ***
// front-panel button and indicator controller with apb registers
// assumes synchronous inputs, one clock pclk, apb master outside
`timescale 1ns/1ps
module ui_ctrl
    import ui_pkg::*;
#(
    parameter int MS_DIV = MS_CYCLES
)
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic [NUM_BUTTONS-1:0] button,
    input  wire logic [NUM_LEADS-1:0]   lead_good,
    input  wire logic                   battery_low,
    input  wire logic                   prog_valid,
    input  wire config_t                prog_cfg,
    output logic      [NUM_LEADS-1:0]   lead_led,
    output logic                        battery_led,
    output logic                        pause_led,
    output msg_t                        msg,
    output logic                        irq
);

    // =====================================================
    // state
    typedef struct packed {
        logic [16:0]          div;
        logic                 tick;
        phase_t               phase;
        logic [9:0]           seq_ms;
        logic [3:0]           seq_cnt;
        logic [1:0]           ack_cnt;
        logic [7:0]           ack_ms;
        logic                 lead_on;
        logic [15:0]          lead_ms;
        logic [NUM_LEADS-1:0] lead_mask;
        logic [9:0]           blink_ms;
        logic                 pause_act;
        logic [9:0]           pause_ms;
        logic [15:0]          pause_sec;
        logic                 pend;
        logic [6:0]           pend_ms;
        logic                 pend_lead;
        logic                 pend_graph;
        logic                 pend_both;
        logic [3:0]           req;
        logic [1:0]           ctrl;
        logic [15:0]          pause_dur;
        config_t              cfg;
        logic [3:0]           irq_sts;
        logic [3:0]           irq_en;
        logic [31:0]          prdata;
        logic                 pready;
        logic                 pslverr;
        logic [NUM_LEADS-1:0] lead_led;
        logic                 battery_led;
        logic                 pause_led;
        msg_t                 msg;
        logic                 irq;
    } ui_state_t;

    ui_state_t state_ff;
    ui_state_t nxt_state;

    logic [NUM_BUTTONS-1:0] btn_level;
    logic [NUM_BUTTONS-1:0] btn_press;

    // =====================================================
    // button filter
    // debounce inputs
    btn_debounce u_debounce (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (state_ff.tick),
        .raw     (button),
        .level   (btn_level),
        .press   (btn_press)
    );

    // lowest pending request
    function automatic logic [3:0] first_bit(input logic [3:0] v);
        logic [3:0] r;
        r = v & (~v + 4'h1);
        return r;
    endfunction

    function automatic logic [1:0] bit_index(input logic [3:0] v);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 3; i >= 0; i--) begin
            if (v[i]) begin
                r = 2'(i);
            end
        end
        return r;
    endfunction

    // =====================================================
    // next state
    always_comb begin
        logic       run;
        logic       service;
        logic       resolve;
        logic       flash;
        logic [3:0] new_req;
        logic [3:0] ev;
        logic [3:0] sent;
        logic       apb_go;
        run       = (state_ff.phase == PH_RUN);
        service   = state_ff.ctrl[CTRL_SERVICE_BIT];
        resolve   = 1'b0;
        flash     = 1'b0;
        new_req   = '0;
        ev        = '0;
        sent      = '0;
        apb_go    = 1'b0;
        nxt_state = state_ff;
        nxt_state.tick = 1'b0;

        // millisecond tick
        if (state_ff.div == 17'(MS_DIV - 1)) begin
            nxt_state.div  = '0;
            nxt_state.tick = 1'b1;
        end else begin
            nxt_state.div = state_ff.div + 17'h00001;
        end

        if (state_ff.tick) begin
            if (state_ff.blink_ms == 10'(BLINK_PERIOD_MS - 1)) begin
                nxt_state.blink_ms = '0;
            end else begin
                nxt_state.blink_ms = state_ff.blink_ms + 10'h001;
            end
        end

        if (!run && state_ff.tick) begin
            if ((state_ff.phase == PH_FAST
                 && state_ff.seq_ms == 10'(FAST_PERIOD_MS - 1))
                || (state_ff.phase == PH_SLOW
                 && state_ff.seq_ms == 10'(SLOW_PERIOD_MS - 1))) begin
                nxt_state.seq_ms  = '0;
                nxt_state.seq_cnt = state_ff.seq_cnt + 4'h1;
                if (state_ff.phase == PH_FAST
                    && state_ff.seq_cnt == 4'(FAST_FLASHES - 1)) begin
                    nxt_state.phase   = PH_SLOW;
                    nxt_state.seq_cnt = '0;
                end else if (state_ff.phase == PH_SLOW
                    && state_ff.seq_cnt == 4'(SLOW_FLASHES - 1)) begin
                    nxt_state.phase   = PH_RUN;
                    nxt_state.seq_cnt = '0;
                end
            end else begin
                nxt_state.seq_ms = state_ff.seq_ms + 10'h001;
            end
        end

        // overlap window for the two-button combination
        // service mode ignores lead and graph buttons
        if (run && !service) begin
            if (btn_press[BTN_LEAD] || btn_press[BTN_GRAPH]) begin
                nxt_state.pend = 1'b1;
                nxt_state.pend_lead  = state_ff.pend_lead
                                       | btn_press[BTN_LEAD];
                nxt_state.pend_graph = state_ff.pend_graph
                                       | btn_press[BTN_GRAPH];
            end
            if (state_ff.pend) begin
                if (btn_level[BTN_LEAD] && btn_level[BTN_GRAPH]) begin
                    nxt_state.pend_both = 1'b1;
                end
                if (state_ff.tick) begin
                    if (state_ff.pend_ms == 7'(COMBO_MS - 1)) begin
                        resolve = 1'b1;
                    end else begin
                        nxt_state.pend_ms = state_ff.pend_ms + 7'h01;
                    end
                end
            end
        end else begin
            nxt_state.pend       = 1'b0;
            nxt_state.pend_ms    = '0;
            nxt_state.pend_lead  = 1'b0;
            nxt_state.pend_graph = 1'b0;
            nxt_state.pend_both  = 1'b0;
        end

        if (resolve) begin
            nxt_state.pend       = 1'b0;
            nxt_state.pend_ms    = '0;
            nxt_state.pend_lead  = 1'b0;
            nxt_state.pend_graph = 1'b0;
            nxt_state.pend_both  = 1'b0;
            flash = 1'b1;
            if (state_ff.pend_both
                || (state_ff.pend_lead && state_ff.pend_graph)) begin
                if (state_ff.pause_act) begin
                    nxt_state.pause_act    = 1'b0;
                    new_req[MSG_PAUSE_OFF] = 1'b1;
                    ev[EV_PAUSE_END]       = 1'b1;
                end else begin
                    nxt_state.pause_act   = 1'b1;
                    nxt_state.pause_ms    = '0;
                    nxt_state.pause_sec   = '0;
                    new_req[MSG_PAUSE_ON] = 1'b1;
                    ev[EV_PAUSE_START]    = 1'b1;
                end
            end else if (state_ff.pend_graph) begin
                new_req[MSG_STRIP] = 1'b1;
            end else begin
                // latch good leads for one minute
                nxt_state.lead_on   = 1'b1;
                nxt_state.lead_ms   = '0;
                nxt_state.lead_mask = lead_good;
            end
        end

        if (run && btn_press[BTN_EVENT]) begin
            flash = 1'b1;
            new_req[MSG_EVENT] = state_ff.ctrl[CTRL_EVENT_EN_BIT];
        end

        if (flash) begin
            nxt_state.ack_cnt = 2'(ACK_FLASHES);
            nxt_state.ack_ms  = '0;
        end else if (state_ff.ack_cnt != 2'h0 && state_ff.tick) begin
            if (state_ff.ack_ms == 8'(ACK_PERIOD_MS - 1)) begin
                nxt_state.ack_ms  = '0;
                nxt_state.ack_cnt = state_ff.ack_cnt - 2'h1;
            end else begin
                nxt_state.ack_ms = state_ff.ack_ms + 8'h01;
            end
        end

        if (state_ff.lead_on && state_ff.tick && !resolve) begin
            if (state_ff.lead_ms == 16'(LEAD_HOLD_MS - 1)) begin
                nxt_state.lead_on = 1'b0;
            end else begin
                nxt_state.lead_ms = state_ff.lead_ms + 16'h0001;
            end
        end

        if (state_ff.pause_act && state_ff.tick && !resolve) begin
            if (state_ff.pause_ms == 10'(BLINK_PERIOD_MS - 1)) begin
                nxt_state.pause_ms  = '0;
                nxt_state.pause_sec = state_ff.pause_sec + 16'h0001;
                if (state_ff.pause_sec + 16'h0001
                    >= state_ff.pause_dur) begin
                    nxt_state.pause_act    = 1'b0;
                    new_req[MSG_PAUSE_OFF] = 1'b1;
                    ev[EV_PAUSE_END]       = 1'b1;
                end
            end else begin
                nxt_state.pause_ms = state_ff.pause_ms + 10'h001;
            end
        end

        // one message per cycle, lowest code first
        sent = first_bit(state_ff.req);
        nxt_state.req       = (state_ff.req & ~sent) | new_req;
        nxt_state.msg.valid = (sent != 4'h0);
        nxt_state.msg.code  = msg_code_t'(bit_index(sent));
        ev[EV_MSG_SENT]     = (sent != 4'h0);

        if (prog_valid) begin
            nxt_state.cfg       = prog_cfg;
            ev[EV_CFG_LOADED]   = 1'b1;
        end

        // apb slave, one wait state
        nxt_state.pready  = psel && penable && !state_ff.pready;
        nxt_state.pslverr = 1'b0;
        if (psel && penable && !state_ff.pready) begin
            nxt_state.prdata = '0;
            unique case (paddr)
                OFS_CTRL:      nxt_state.prdata[1:0] = state_ff.ctrl;
                OFS_PAUSE_DUR: nxt_state.prdata[15:0] = state_ff.pause_dur;
                OFS_CONFIG: begin
                    nxt_state.prdata[15:0] = state_ff.cfg.ident;
                    nxt_state.prdata[CFG_LEAD_POS +: 3] =
                        state_ff.cfg.ref_lead;
                end
                OFS_STATUS: begin
                    nxt_state.prdata[1:0]  = state_ff.phase;
                    nxt_state.prdata[2]    = state_ff.pause_act;
                    nxt_state.prdata[3]    = battery_low;
                    nxt_state.prdata[4]    = state_ff.lead_on;
                    nxt_state.prdata[13:8] = state_ff.lead_mask;
                end
                OFS_IRQ_STS:   nxt_state.prdata[3:0] = state_ff.irq_sts;
                OFS_IRQ_CLR:   nxt_state.prdata = '0;
                OFS_IRQ_EN:    nxt_state.prdata[3:0] = state_ff.irq_en;
                default:       nxt_state.pslverr = 1'b1;
            endcase
        end
        apb_go = psel && penable && state_ff.pready && pwrite
                 && !state_ff.pslverr;

        // sticky status, set wins over clear
        nxt_state.irq_sts = state_ff.irq_sts | ev;
        if (apb_go) begin
            unique case (paddr)
                OFS_CTRL:      nxt_state.ctrl = pwdata[1:0];
                OFS_PAUSE_DUR: nxt_state.pause_dur = pwdata[15:0];
                OFS_IRQ_CLR:   nxt_state.irq_sts =
                                   (state_ff.irq_sts & ~pwdata[3:0]) | ev;
                OFS_IRQ_EN:    nxt_state.irq_en = pwdata[3:0];
                default:       nxt_state.ctrl = state_ff.ctrl;
            endcase
        end
        nxt_state.irq = |(nxt_state.irq_sts & nxt_state.irq_en);

        // indicator outputs, startup then ack then lead hold
        if (nxt_state.phase == PH_FAST) begin
            nxt_state.lead_led = {NUM_LEADS{
                nxt_state.seq_ms < 10'(FAST_ON_MS)}};
        end else if (nxt_state.phase == PH_SLOW) begin
            nxt_state.lead_led = {NUM_LEADS{
                nxt_state.seq_ms < 10'(SLOW_ON_MS)}};
        end else if (nxt_state.ack_cnt != 2'h0) begin
            nxt_state.lead_led = {NUM_LEADS{
                nxt_state.ack_ms < 8'(ACK_ON_MS)}};
        end else if (nxt_state.lead_on) begin
            nxt_state.lead_led = nxt_state.lead_mask;
        end else begin
            nxt_state.lead_led = '0;
        end
        nxt_state.battery_led = battery_low
            && nxt_state.blink_ms < 10'(BLINK_ON_MS);
        nxt_state.pause_led = nxt_state.pause_act
            && nxt_state.blink_ms < 10'(BLINK_ON_MS);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff           <= '0;
            state_ff.phase     <= PH_FAST;
            state_ff.ctrl      <= CTRL_RESET;
            state_ff.pause_dur <= PAUSE_DUR_RESET;
            state_ff.lead_led  <= '1;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // =====================================================
    // outputs
    assign prdata      = state_ff.prdata;
    assign pready      = state_ff.pready;
    assign pslverr     = state_ff.pslverr;
    assign lead_led    = state_ff.lead_led;
    assign battery_led = state_ff.battery_led;
    assign pause_led   = state_ff.pause_led;
    assign msg         = state_ff.msg;
    assign irq         = state_ff.irq;

endmodule

// *** shared/ui_pkg.sv ***
// package of the front-panel button and indicator controller
// assumes a 100 MHz pclk and an apb master with 32-bit data
package ui_pkg;

    // =====================================================
    // timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int TICK_PERIOD_NS = 1000000;
    localparam int MS_CYCLES      = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int FAST_PERIOD_MS = 100;
    localparam int FAST_ON_MS     = 50;
    localparam int FAST_FLASHES   = 8;
    localparam int SLOW_PERIOD_MS = 1000;
    localparam int SLOW_ON_MS     = 500;
    localparam int SLOW_FLASHES   = 2;
    localparam int ACK_PERIOD_MS  = 200;
    localparam int ACK_ON_MS      = 100;
    localparam int ACK_FLASHES    = 2;
    localparam int LEAD_HOLD_MIN  = 1;
    localparam int LEAD_HOLD_MS   = LEAD_HOLD_MIN * 60000;
    localparam int BLINK_PERIOD_S = 1;
    localparam int BLINK_PERIOD_MS = BLINK_PERIOD_S * 1000;
    localparam int BLINK_ON_MS    = BLINK_PERIOD_MS / 8;
    localparam int DEBOUNCE_MS    = 20;
    localparam int COMBO_MS       = 100;

    // =====================================================
    // sizes
    localparam int NUM_LEADS   = 6;
    localparam int NUM_BUTTONS = 3;
    localparam int BTN_LEAD    = 0;
    localparam int BTN_GRAPH   = 1;
    localparam int BTN_EVENT   = 2;

    // =====================================================
    // register map
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_PAUSE_DUR = 8'h04;
    localparam logic [7:0] OFS_CONFIG    = 8'h08;
    localparam logic [7:0] OFS_STATUS    = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STS   = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR   = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN    = 8'h18;

    localparam int CTRL_EVENT_EN_BIT = 0;
    localparam int CTRL_SERVICE_BIT  = 1;
    localparam logic [1:0]  CTRL_RESET      = 2'h1;
    localparam logic [15:0] PAUSE_DUR_RESET = 16'h012C;
    localparam int CFG_LEAD_POS = 16;

    // irq and message bits
    localparam int EV_MSG_SENT    = 0;
    localparam int EV_PAUSE_START = 1;
    localparam int EV_PAUSE_END   = 2;
    localparam int EV_CFG_LOADED  = 3;

    typedef enum logic [1:0] {
        MSG_STRIP,
        MSG_PAUSE_ON,
        MSG_PAUSE_OFF,
        MSG_EVENT
    } msg_code_t;

    typedef enum logic [1:0] {
        PH_FAST,
        PH_SLOW,
        PH_RUN
    } phase_t;

    typedef struct packed {
        logic [15:0] ident;
        logic [2:0]  ref_lead;
    } config_t;

    typedef struct packed {
        logic        valid;
        msg_code_t   code;
    } msg_t;

endpackage

// *** src/btn_debounce.sv ***
// debounce for the user buttons, counted in millisecond ticks
// assumes buttons are synchronous, high while pressed
`timescale 1ns/1ps
module btn_debounce
    import ui_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   tick,
    input  wire logic [NUM_BUTTONS-1:0] raw,
    output logic      [NUM_BUTTONS-1:0] level,
    output logic      [NUM_BUTTONS-1:0] press
);

    // =====================================================
    // state
    typedef struct packed {
        logic [NUM_BUTTONS-1:0][4:0] cnt;
        logic [NUM_BUTTONS-1:0]      level;
        logic [NUM_BUTTONS-1:0]      press;
    } deb_state_t;

    deb_state_t state_ff;
    deb_state_t nxt_state;

    // =====================================================
    // per-button filter
    always_comb begin
        nxt_state       = state_ff;
        nxt_state.press = '0;
        for (int i = 0; i < NUM_BUTTONS; i++) begin
            if (raw[i] == state_ff.level[i]) begin
                nxt_state.cnt[i] = '0;
            end else if (tick) begin
                if (state_ff.cnt[i] == 5'(DEBOUNCE_MS - 1)) begin
                    nxt_state.cnt[i]   = '0;
                    nxt_state.level[i] = raw[i];
                    nxt_state.press[i] = raw[i];
                end else begin
                    nxt_state.cnt[i] = state_ff.cnt[i] + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign level = state_ff.level;
    assign press = state_ff.press;

endmodule

// *** dv/ui_ctrl_chk.sv ***
// checker of the apb, indicator and irq ports of ui_ctrl
// assumes binding onto ui_ctrl, one clock pclk
`timescale 1ns/1ps
module ui_ctrl_chk
    import ui_pkg::*;
#(
    parameter int MS_DIV = MS_CYCLES
)
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        battery_low,
    input wire logic        battery_led,
    input wire logic        pause_led,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // =====================
    // run length of pause led
    logic [31:0] on_ff;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_ff <= 32'h0;
        end else begin
            on_ff <= pause_led ? on_ff + 32'h1 : 32'h0;
        end
    end
    // =====================
    // assertions
    ready_follows_a: assert property (psel && penable && !pready |=> pready)
        else $error("no ready after access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_with_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    unmapped_err_a: assert property (pready && paddr > OFS_IRQ_EN
        |-> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    clr_reads_zero_a: assert property (pready && !pwrite
        && paddr == OFS_IRQ_CLR |-> prdata == 32'h0)
        else $error("clear register read not zero");
    batt_dark_a: assert property (
        !battery_low [*3] |-> !battery_led) else $error("battery led lit");
    pause_on_time_a: assert property (
        on_ff <= BLINK_ON_MS * MS_DIV) else $error("pause led on too long");
    irq_masked_a: assert property (pready && pwrite && paddr == OFS_IRQ_EN
        && pwdata[3:0] == 4'h0 |-> ##2 !irq) else $error("irq not masked");
endmodule

bind ui_ctrl ui_ctrl_chk #(.MS_DIV(MS_DIV)) chk_u (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .battery_low, .battery_led, .pause_led, .irq);

// *** dv/station_model.sv ***
// model of the remote station: logs each request by its code
// assumes msg valid is a one-cycle pulse on pclk
`timescale 1ns/1ps
module station_model
    import ui_pkg::*;
(
    input wire logic pclk,
    input wire msg_t msg
);
    // =====================
    // request log
    int n_rx [4] = '{0, 0, 0, 0};
    always_ff @(posedge pclk) begin
        if (msg.valid === 1'b1) begin
            n_rx[msg.code] <= n_rx[msg.code] + 1;
        end
    end
endmodule

// *** dv/button_led_ui_controller_bench.sv ***
// bench of ui_ctrl: apb tasks, button presses, request counts
// assumes ui_pkg, ui_ctrl, ui_ctrl_chk and station_model
`timescale 1ns/1ps
module button_led_ui_controller_bench
    import ui_pkg::*;
();
    localparam int MS = 4;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        battery_low, prog_valid, battery_led, pause_led, irq, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  button;
    logic [5:0]  lead_good, lead_led;
    config_t     prog_cfg;
    msg_t        msg;
    int          n_mismatch = 0, compares = 0, n_on = 0, cyc = 0;
    int          exp_rx [4] = '{0, 0, 0, 0};

    ui_ctrl #(.MS_DIV(MS)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .button, .lead_good,
        .battery_low, .prog_valid, .prog_cfg, .lead_led, .battery_led,
        .pause_led, .msg, .irq);
    station_model station_u (.pclk, .msg);

    // =====================
    // clock and timeout
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch = n_mismatch + 1;
            conclude();
        end
    end
    // =====================
    // tasks
    task automatic conclude();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask
    task automatic press(input logic [2:0] b);
        button <= b;
        repeat (40 * MS) @(posedge pclk);
        button <= 3'h0;
        n_on = 0;
        repeat (600 * MS) @(posedge pclk) n_on += (lead_led === 6'h3F);
    endtask
    task automatic rx_chk();
        for (int k = 0; k < 4; k++) begin
            chk("request count", exp_rx[k], station_u.n_rx[k]);
        end
    endtask
    task automatic blink(input logic batt);
        n_on = 0;
        repeat (1000 * MS) @(posedge pclk)
            n_on += ((batt ? battery_led : pause_led) === 1'b1);
    endtask
    // =====================
    // tests
    initial begin
        {presetn, psel, penable, pwrite, prog_valid, battery_low} = 6'h0;
        {paddr, pwdata, button, prog_cfg} = '0;
        lead_good = 6'h2D;
        repeat (3) @(posedge pclk);
        chk("reset leds", 32'h3F, lead_led);
        presetn <= 1'b1;
        rdc("ctrl", OFS_CTRL, 32'h1);
        rdc("pause dur", OFS_PAUSE_DUR, 32'h12C);
        rdc("irq en", OFS_IRQ_EN, 32'h0);
        apb(1'b0, 8'h1C, 32'h0);
        chk("unmapped", 32'h1, err);
        press(3'h2);
        rx_chk();
        repeat (2800 * MS) @(posedge pclk);
        apb(1'b1, OFS_IRQ_EN, 32'hF);
        rdc("phase", OFS_STATUS, 32'h2);
        press(3'h2);
        exp_rx[0]++;
        rx_chk();
        chk("ack on", 2 * ACK_ON_MS * MS, n_on);
        press(3'h4);
        exp_rx[3]++;
        rx_chk();
        chk("irq up", 32'h1, irq);
        apb(1'b1, OFS_IRQ_CLR, 32'hF);
        rdc("sts clear", OFS_IRQ_STS, 32'h0);
        rdc("clr reads", OFS_IRQ_CLR, 32'h0);
        apb(1'b1, OFS_IRQ_EN, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h0);
        press(3'h4);
        rx_chk();
        apb(1'b1, OFS_CTRL, 32'h3);
        press(3'h2);
        press(3'h1);
        press(3'h4);
        exp_rx[3]++;
        rx_chk();
        chk("service leds", 32'h0, lead_led);
        rdc("sts masked", OFS_IRQ_STS, 32'h1);
        chk("irq masked", 32'h0, irq);
        apb(1'b1, OFS_CTRL, 32'h1);
        press(3'h1);
        chk("lead hold", 32'h2D, lead_led);
        apb(1'b1, OFS_PAUSE_DUR, 32'h3);
        press(3'h3);
        exp_rx[1]++;
        rx_chk();
        blink(1'b0);
        chk("pause blink", BLINK_ON_MS * MS, n_on);
        repeat (1800 * MS) @(posedge pclk);
        exp_rx[2]++;
        rx_chk();
        apb(1'b1, OFS_PAUSE_DUR, 32'hA);
        press(3'h3);
        press(3'h3);
        exp_rx[1]++;
        exp_rx[2]++;
        rx_chk();
        chk("pause led", 32'h0, pause_led);
        battery_low <= 1'b1;
        repeat (10) @(posedge pclk);
        blink(1'b1);
        chk("battery blink", BLINK_ON_MS * MS, n_on);
        prog_cfg <= {16'hA5C3, 3'h5};
        prog_valid <= 1'b1;
        @(posedge pclk);
        prog_valid <= 1'b0;
        rdc("config", OFS_CONFIG, 32'h0005A5C3);
        conclude();
    end
endmodule
